/* verif/capture_side_model.sv */
// Capture-side model: drives the alignment pin, counts captures and markers.
// Assumes the bench runs the conversion clock freely.
`timescale 1ns/1ns
module capture_side_model
   import output_align_pkg::*;
(
   input  wire logic              i_conv_clk,
   input  wire logic [1:0]        i_form,
   input  wire logic [2:0]        i_gap,
   input  wire logic [DATA_W-1:0] i_sample_data,
   input  wire logic [DATA_W-1:0] i_bus_a_data,
   input  wire logic              i_marker,
   output logic                   o_alignment_pulse_pos = 1'b0,
   output int                     o_captures,
   output int                     o_markers,
   output logic [DATA_W-1:0]      o_captured,
   output logic [DATA_W-1:0]      o_marked_word,
   output realtime                o_cap_time,
   output realtime                o_mark_time
);
   logic       shot_q = 1'b0;
   logic       seen_q = 1'b0;
   logic [2:0] gap_q  = 3'h0;
   // ------------------------------------------------------------
   // Pin moves on rising edges, so it stands around the falling one
   // ------------------------------------------------------------
   always @(posedge i_conv_clk)
   begin
      gap_q <= (gap_q + 3'h1 >= i_gap) ? 3'h0 : gap_q + 3'h1;
      case (i_form)
         2'h1: o_alignment_pulse_pos <= ~shot_q;
         2'h2: o_alignment_pulse_pos <= 1'b1;
         2'h3: o_alignment_pulse_pos <= (gap_q == 3'h0);
         default: o_alignment_pulse_pos <= 1'b0;
      endcase
      shot_q <= (i_form == 2'h1);
   end
   always @(negedge i_conv_clk)
   begin
      if (o_alignment_pulse_pos && !seen_q)
      begin
         o_captures <= o_captures + 1;
         o_captured <= i_sample_data;
         o_cap_time <= $realtime;
      end
      seen_q <= o_alignment_pulse_pos;
   end
   // Short wait lets the word register land beside the marker
   always @(posedge i_marker)
   begin
      #1;
      o_markers = o_markers + 1;
      o_marked_word = i_bus_a_data;
      o_mark_time = $realtime - 1;
   end
endmodule // capture_side_model

/* verif/output_clock_sync_alignment_tb.sv */
// Bench for the output clock, bus split and marker logic.
// Assumes the partner model above; conversion clock 320 ns, free running.
`timescale 1ns/1ns
module output_clock_sync_alignment_tb;
   import output_align_pkg::*;
   logic              i_clk = 1'b0;
   logic              i_rst = 1'b1;
   logic              conv_clk = 1'b0;
   logic              single_sel = 1'b1;
   logic              stagger_sel = 1'b0;
   logic [DATA_W-1:0] sample_data = 12'h000;
   logic [DATA_W-1:0] bus_a, bus_b, captured, marked_word, late_b;
   logic              sample_clk, mark_a, mark_b, align;
   logic [1:0]        form = 2'h0;
   logic [2:0]        gap = 3'h1;
   int                captures, markers, bad_count, checked, cycles, b_dirty;
   realtime           cap_time, mark_time, last_rise;

   output_clock_sync_alignment output_clock_sync_alignment_inst (
      .i_clk(i_clk), .i_rst(i_rst), .i_conversion_clock_in(conv_clk),
      .i_alignment_pulse_pos(align), .i_single_bus_select(single_sel),
      .i_stagger_select(stagger_sel), .i_sample_data(sample_data),
      .o_sample_clock_out(sample_clk), .o_bus_a_data(bus_a), .o_bus_b_data(bus_b),
      .o_marker_out_bus_a(mark_a), .o_marker_out_bus_b(mark_b));
   capture_side_model capture_side_model_inst (
      .i_conv_clk(conv_clk), .i_form(form), .i_gap(gap), .i_sample_data(sample_data),
      .i_bus_a_data(bus_a), .i_marker(mark_a | mark_b), .o_alignment_pulse_pos(align),
      .o_captures(captures), .o_markers(markers), .o_captured(captured),
      .o_marked_word(marked_word), .o_cap_time(cap_time), .o_mark_time(mark_time));

   // ------------------------------------------------------------
   // Clocks, data source and watchers
   // ------------------------------------------------------------
   always #20 i_clk = ~i_clk;
   always #160 conv_clk = ~conv_clk;
   always @(posedge conv_clk) sample_data <= sample_data + 12'h1;
   always @(posedge sample_clk) last_rise = $realtime;
   always @(posedge mark_b)
   begin
      #500;
      late_b = bus_b;
   end
   always @(posedge i_clk)
   begin
      cycles <= cycles + 1;
      if (single_sel && (bus_b !== 12'h000 || mark_b !== 1'b0))
         b_dirty <= b_dirty + 1;
      if (cycles == 20000)
      begin
         bad_count = bad_count + 1;
         final_report();
      end
   end

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked = checked + 1;
      if (seen !== exp)
      begin
         bad_count = bad_count + 1;
         $display("Error %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic final_report;
      $display("checked %0d bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic set_mode(input logic single, input logic stag);
      @(posedge i_clk);
      single_sel <= single;
      stagger_sel <= stag;
      repeat (64) @(posedge i_clk);
   endtask
   task automatic fire(input logic [1:0] f, input logic [2:0] g, input int n);
      @(posedge i_clk);
      form <= f;
      gap <= g;
      repeat (n * 8) @(posedge i_clk);
      form <= 2'h0;
      repeat (100) @(posedge i_clk);
   endtask
   task automatic meas_period(input int exp);
      realtime t0;
      @(posedge sample_clk);
      t0 = $realtime;
      @(posedge sample_clk);
      check("clock_period", int'($realtime - t0), exp);
   endtask
   // Sync delay quantises to system cycles, hence the window
   task automatic lat_check(input int lo);
      int lat;
      lat = int'(mark_time - cap_time);
      check("latency", (lat >= lo) && (lat <= lo + 240), 1);
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_single(input logic [1:0] f, input int n);
      int c0, m0, d0;
      set_mode(1'b1, 1'b0);
      c0 = captures;
      m0 = markers;
      d0 = b_dirty;
      fire(f, 3'h1, n);
      check("captures", captures - c0, 1);
      check("markers", markers - m0, 1);
      check("marked_word", marked_word, captured);
      lat_check(2240);
      check("bus_b_idle", b_dirty - d0, 0);
   endtask
   task automatic t_dual(input logic stag);
      int c0, m0, ph1, per;
      logic [DATA_W-1:0] exp_b;
      per = stag ? 1280 : 640;
      set_mode(1'b0, stag);
      meas_period(per);
      c0 = captures;
      m0 = markers;
      fire(2'h1, 3'h1, 1);
      check("captures", captures - c0, 1);
      check("markers", markers - m0, 1);
      check("marked_word", marked_word, captured);
      lat_check(2400);
      exp_b = stag ? captured + 12'h1 : captured - 12'h1;
      check("bus_b", late_b, exp_b);
      ph1 = int'(last_rise - cap_time) % per;
      repeat (8) @(posedge i_clk);
      fire(2'h1, 3'h1, 1);
      check("phase", int'(last_rise - cap_time) % per, ph1);
   endtask
   task automatic t_train(input logic stag);
      int c0, m0;
      set_mode(1'b0, stag);
      c0 = captures;
      m0 = markers;
      fire(2'h3, stag ? 3'h4 : 3'h2, 16);
      check("train_captures", captures - c0, stag ? 4 : 8);
      check("train_markers", markers - m0, stag ? 4 : 8);
      meas_period(stag ? 1280 : 640);
   endtask

   initial
   begin
      repeat (6) @(posedge i_clk);
      i_rst <= 1'b0;
      repeat (8) @(posedge i_clk);
      t_single(2'h1, 1);
      t_single(2'h2, 6);
      t_dual(1'b0);
      t_dual(1'b1);
      t_train(1'b0);
      t_train(1'b1);
      final_report();
   end
endmodule // output_clock_sync_alignment_tb

/* verilog/half_step_pipe.sv */
// Delay line advancing once per conversion clock edge.
// Assumes i_shift is a one-cycle pulse in the i_clk domain.
`timescale 1ns/1ns
module half_step_pipe
   import output_align_pkg::*;
#(
   parameter int WIDTH = WORD_W,
   parameter int DEPTH = PIPE_DEPTH
)(
   input  wire logic                        i_clk,
   input  wire logic                        i_rst,
   input  wire logic                        i_shift,
   input  wire logic [WIDTH-1:0]            i_word,
   output logic      [DEPTH-1:0][WIDTH-1:0] o_taps
);
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         o_taps <= '0;
      end
      else if (i_shift)
      begin
         o_taps[0] <= i_word;
         for (int k = 1; k < DEPTH; k++)
         begin
            o_taps[k] <= o_taps[k-1];
         end
      end
   end
endmodule // half_step_pipe

/* verilog/output_align_pkg.sv */
// Shared constants for the output clock and alignment marker logic.
// Assumes one system clock domain; converter pins are sampled into it.
package output_align_pkg;
   // -------------------------------------------------------------
   // Word layout
   // -------------------------------------------------------------
   localparam int DATA_W   = 12;
   localparam int MARK_BIT = 12;
   localparam int PAR_BIT  = 13;
   localparam int WORD_W   = 14;

   // -------------------------------------------------------------
   // Latency in half cycles of the conversion clock
   // -------------------------------------------------------------
   localparam int HALF_PER_CYCLE  = 2;
   localparam int LAT_SINGLE_X2   = 7 * HALF_PER_CYCLE;
   localparam int LAT_DUAL_A_X2   = 15;
   localparam int LAT_ALIGN_B_X2  = 17;
   localparam int PIPE_DEPTH      = LAT_ALIGN_B_X2;

   // -------------------------------------------------------------
   // Divider and sampling
   // -------------------------------------------------------------
   localparam int           DIV_W       = 2;
   localparam logic [1:0]   DIV_PHASE   = 2'h0;
   localparam int           DIV2_BIT    = 0;
   localparam int           DIV4_BIT    = 1;
   localparam int           SYNC_W      = 16;
   localparam int           CLK_PERIOD_NS      = 40;
   localparam int           LINK_PERIOD_NS     = 320;
   localparam int           LINK_HALF_CYCLES   = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);

   // -------------------------------------------------------------
   // Output modes, one-hot
   // -------------------------------------------------------------
   typedef enum logic [2:0] {
      MODE_SINGLE  = 3'h1,
      MODE_ALIGNED = 3'h2,
      MODE_STAGGER = 3'h4
   } out_mode_t;
endpackage

/* verilog/output_clock_sync_alignment.sv */
// Output side of the converter: divided sample clock, bus split and marker.
// Assumes the conversion clock and all pins are slower than i_clk by 8x.
// Operation
// (RULE1) Single-bus mode: bus B stays idle
// (RULE2) Each captured pulse gives one marker
// (RULE3) Single-bus marker A follows captured sample
// (RULE4) Two-bus marker B follows captured sample
// (RULE5) Pulse, step or train all accepted
// (RULE6) Divide-by-2 pulse train at most half rate
// (RULE7) Divide-by-4 pulse train at most quarter rate
// (RULE8) Alignment is optional; phase otherwise arbitrary
// (RULE9) Aligned two-bus: sample clock input/2
// (RULE10) Staggered two-bus: sample clock input/4
// (RULE11) Latency 7 single, 7.5 staggered
// (RULE12) Aligned latency 7.5 bus A, 8.5 B
// (RULE13) Pulse sampled on falling input clock edge
// (RULE14) Capture restarts divider at fixed phase
`timescale 1ns/1ns
module output_clock_sync_alignment
   import output_align_pkg::*;
(
   input  wire logic              i_clk,
   input  wire logic              i_rst,
   input  wire logic              i_conversion_clock_in,
   input  wire logic              i_alignment_pulse_pos,
   input  wire logic              i_single_bus_select,
   input  wire logic              i_stagger_select,
   input  wire logic [DATA_W-1:0] i_sample_data,
   output logic                   o_sample_clock_out,
   output logic      [DATA_W-1:0] o_bus_a_data,
   output logic      [DATA_W-1:0] o_bus_b_data,
   output logic                   o_marker_out_bus_a,
   output logic                   o_marker_out_bus_b
);
   // -------------------------------------------------------------
   // Pin synchronisers
   // -------------------------------------------------------------
   logic [SYNC_W-1:0] sync1_q;
   logic [SYNC_W-1:0] sync2_q;
   logic              clk_prev_q;
   logic              conv_clk;
   logic              align_in;
   logic              rise_e;
   logic              fall_e;

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         sync1_q <= '0;
         sync2_q <= '0;
      end
      else
      begin
         sync1_q <= {i_conversion_clock_in, i_alignment_pulse_pos,
                     i_single_bus_select, i_stagger_select, i_sample_data};
         sync2_q <= sync1_q;
      end
   end

   assign conv_clk = sync2_q[SYNC_W-1];
   assign align_in = sync2_q[SYNC_W-2];

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         clk_prev_q <= 1'b0;
      else
         clk_prev_q <= conv_clk;
   end

   assign rise_e = conv_clk & ~clk_prev_q;
   assign fall_e = ~conv_clk & clk_prev_q;

   // -------------------------------------------------------------
   // Mode selection
   // -------------------------------------------------------------
   out_mode_t mode_q;

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         mode_q <= MODE_SINGLE;
      else if (sync2_q[SYNC_W-3])
         mode_q <= MODE_SINGLE;
      else if (sync2_q[SYNC_W-4])
         mode_q <= MODE_STAGGER;
      else
         mode_q <= MODE_ALIGNED;
   end

   // -------------------------------------------------------------
   // Alignment capture
   // -------------------------------------------------------------
   // Edge of the sampled level, so a step counts once and a train each time
   logic align_last_q;
   logic capture;

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         align_last_q <= 1'b0;
      else if (fall_e)
         align_last_q <= align_in; // [RULE13]
   end

   assign capture = fall_e & align_in & ~align_last_q; // [RULE5] [RULE13]

   // -------------------------------------------------------------
   // Sample clock divider
   // -------------------------------------------------------------
   // Restarting on every capture keeps phase fixed under legal trains
   logic [DIV_W-1:0] div_q;

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         div_q <= DIV_PHASE;
      else if (capture)
         div_q <= DIV_PHASE; // [RULE14] [RULE6] [RULE7]
      else if (rise_e)
         div_q <= div_q + DIV_W'(1); // [RULE8]
   end

   always_comb
   begin
      case (mode_q)
         MODE_STAGGER: o_sample_clock_out = div_q[DIV4_BIT]; // [RULE10]
         default:      o_sample_clock_out = div_q[DIV2_BIT]; // [RULE9]
      endcase
   end

   // -------------------------------------------------------------
   // Sample pipeline
   // -------------------------------------------------------------
   // The marker rides as one more data bit, parity picks the bus
   logic                             par_q;
   logic                             par_d;
   logic [WORD_W-1:0]                hold_q;
   logic [WORD_W-1:0]                new_word;
   logic [WORD_W-1:0]                pipe_in;
   logic [PIPE_DEPTH-1:0][WORD_W-1:0] taps;

   assign par_d    = capture ? 1'b0 : ~par_q;
   assign new_word = {par_d, capture, sync2_q[DATA_W-1:0]}; // [RULE2]
   assign pipe_in  = fall_e ? new_word : hold_q;

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         par_q  <= 1'b1;
         hold_q <= '0;
      end
      else if (fall_e)
      begin
         par_q  <= par_d;
         hold_q <= {par_d, 1'b0, sync2_q[DATA_W-1:0]};
      end
   end

   half_step_pipe #(
      .WIDTH (WORD_W),
      .DEPTH (PIPE_DEPTH)
   ) u_pipe (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_shift (rise_e | fall_e),
      .i_word  (pipe_in),
      .o_taps  (taps)
   );

   // -------------------------------------------------------------
   // Output buses
   // -------------------------------------------------------------
   logic [WORD_W-1:0] tap_single;
   logic [WORD_W-1:0] tap_dual;
   logic [WORD_W-1:0] tap_b_aligned;
   logic              shift_e;

   // Output flop adds the last half step, so read one tap early
   assign tap_single    = taps[LAT_SINGLE_X2-1];
   assign tap_dual      = taps[LAT_DUAL_A_X2-1];
   assign tap_b_aligned = taps[LAT_ALIGN_B_X2-1];
   assign shift_e       = rise_e | fall_e;

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         o_bus_a_data       <= '0;
         o_bus_b_data       <= '0;
         o_marker_out_bus_a <= 1'b0;
         o_marker_out_bus_b <= 1'b0;
      end
      else if (shift_e)
      begin
         case (mode_q)
            MODE_SINGLE:
            begin
               o_bus_a_data       <= tap_single[DATA_W-1:0]; // [RULE11]
               o_marker_out_bus_a <= tap_single[MARK_BIT];   // [RULE3]
               o_bus_b_data       <= '0;                     // [RULE1]
               o_marker_out_bus_b <= 1'b0;                   // [RULE1]
            end
            MODE_ALIGNED:
            begin
               o_marker_out_bus_a <= 1'b0;
               if (!tap_dual[PAR_BIT])
               begin
                  o_bus_a_data       <= tap_dual[DATA_W-1:0];  // [RULE12]
                  o_marker_out_bus_b <= tap_dual[MARK_BIT];    // [RULE4]
               end
               if (tap_b_aligned[PAR_BIT])
                  o_bus_b_data <= tap_b_aligned[DATA_W-1:0];   // [RULE12]
            end
            default:
            begin
               o_marker_out_bus_a <= 1'b0;
               if (!tap_dual[PAR_BIT])
               begin
                  o_bus_a_data       <= tap_dual[DATA_W-1:0];  // [RULE11]
                  o_marker_out_bus_b <= tap_dual[MARK_BIT];    // [RULE4]
               end
               else
                  o_bus_b_data <= tap_dual[DATA_W-1:0];        // [RULE11]
            end
         endcase
      end
   end

   // -------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------
   property p_bus_b_idle;
      @(posedge i_clk) disable iff (i_rst)
      (mode_q == MODE_SINGLE) ##1 (mode_q == MODE_SINGLE) [*8]
         |-> (o_bus_b_data == '0) && !o_marker_out_bus_b;
   endproperty
   a_bus_b_idle: assert property (p_bus_b_idle) // [RULE1]
      else $error("Bus B active in single-bus mode");

   property p_marker_single;
      @(posedge i_clk) disable iff (i_rst)
      capture && (mode_q == MODE_SINGLE) |-> ##[55:59] o_marker_out_bus_a;
   endproperty
   a_marker_single: assert property (p_marker_single) // [RULE3]
      else $error("Single-bus marker missing after capture");

   property p_marker_dual;
      @(posedge i_clk) disable iff (i_rst)
      capture && (mode_q != MODE_SINGLE) |-> ##[59:63] o_marker_out_bus_b;
   endproperty
   a_marker_dual: assert property (p_marker_dual) // [RULE4]
      else $error("Two-bus marker missing after capture");

   property p_marker_once;
      @(posedge i_clk) disable iff (i_rst)
      $rose(o_marker_out_bus_a) |-> ##[1:12] !o_marker_out_bus_a;
   endproperty
   a_marker_once: assert property (p_marker_once) // [RULE2]
      else $error("Marker A stands too long");

   property p_capture_on_fall;
      @(posedge i_clk) disable iff (i_rst)
      capture |-> fall_e && $past(conv_clk) && align_in;
   endproperty
   a_capture_on_fall: assert property (p_capture_on_fall) // [RULE13]
      else $error("Capture outside falling edge");

   property p_div_restart;
      @(posedge i_clk) disable iff (i_rst)
      capture |=> (div_q == DIV_PHASE) && !o_sample_clock_out;
   endproperty
   a_div_restart: assert property (p_div_restart) // [RULE14]
      else $error("Divider not restarted on capture");

   property p_div2_edges;
      @(posedge i_clk) disable iff (i_rst)
      (mode_q == MODE_ALIGNED) && $past(mode_q == MODE_ALIGNED)
         && $changed(o_sample_clock_out) |-> $past(rise_e | capture);
   endproperty
   a_div2_edges: assert property (p_div2_edges) // [RULE9]
      else $error("Half-rate clock moved off an input edge");

   property p_div4_hold;
      @(posedge i_clk) disable iff (i_rst)
      (mode_q == MODE_STAGGER) && rise_e && !capture && !div_q[DIV2_BIT]
         |=> $stable(o_sample_clock_out);
   endproperty
   a_div4_hold: assert property (p_div4_hold) // [RULE10]
      else $error("Quarter-rate clock toggled early");

   property p_latency_single;
      @(posedge i_clk) disable iff (i_rst)
      shift_e && (mode_q == MODE_SINGLE)
         |=> o_bus_a_data == $past(taps[LAT_SINGLE_X2-1][DATA_W-1:0]);
   endproperty
   a_latency_single: assert property (p_latency_single) // [RULE11]
      else $error("Single-bus data not from 7-cycle tap");
endmodule // output_clock_sync_alignment
